// *** src/cvtg_top.sv ***
// Purpose: thirteen phase vertical transfer clock generator
// Assumes: apb slave, sys_clk is the pixel clock
// Notes: every output is registered
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module cvtg_top
   import cvtg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor drive
   output logic [NOUT-1:0] vert_phase,
   output logic horiz_drive
);
   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   logic run_en;
   logic [2:0] mode_cnt;
   logic [1:0] mode_ord [NFIELD];
   logic [15:0] sq_ctrl [NSEQ];
   logic [PW-1:0] sq_start [NSEQ][2];
   logic [PW-1:0] sq_len [NSEQ][2];
   logic [RW-1:0] sq_rep_a [NSEQ][4];
   logic [RW-1:0] sq_rep_b [NSEQ][2];
   logic [PW-1:0] sq_line_len [NSEQ];
   logic [NOUT-1:0] sq_pol [NSEQ];
   logic [NGSEL-1:0] sq_grp [NSEQ];
   logic [PW-1:0] sq_mb [NSEQ][2];
   logic [PW-1:0] sq_me [NSEQ][2];
   logic [3:0] fd_nreg [NFIELD];
   logic [PW-1:0] fd_last [NFIELD];
   logic [RW-1:0] fd_rlines [NFIELD][NREG];
   logic [1:0] fd_rseq [NFIELD][NREG];

   // engine state
   cvtg_state_t state;
   logic [1:0] slot;
   logic [3:0] region;
   logic [RW-1:0] rline;
   logic [1:0] lalt;
   logic [PW-1:0] pix;
   logic g_act [2];
   logic [PW-1:0] g_rel [2];
   logic [RW-1:0] g_cnt [2];

   // combinational
   logic run;
   logic [1:0] fld;
   logic [1:0] cs;
   logic [15:0] sc;
   logic last_reg;
   logic last_rl;
   logic last_slot;
   logic line_end;
   logic [PW-1:0] line_len;
   logic masked;
   logic frozen;
   logic [1:0] a_idx;
   logic [PW-1:0] g_start [2];
   logic [PW-1:0] g_len [2];
   logic [RW-1:0] g_reps [2];
   logic [NOUT-1:0] lvl;

   // apb decode
   logic blk_glb;
   logic blk_seq;
   logic blk_fld;
   logic blk_tog;
   logic [1:0] bi;
   logic [5:0] wo;
   logic [3:0] ri;
   logic wr_done;
   logic [31:0] rd_val;
   logic dec_err;

   cvtg_pat_if pat ();

   cvtg_pattern_mem u_mem (
      .sys_clk(sys_clk),
      .pat(pat)
   );

   // ----------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------
   // one wait state so the toggle memory read has time to land
   assign wr_done = psel & penable & pready & pwrite;
   assign bi = paddr[7:6];
   assign wo = paddr[5:0];
   assign ri = 4'(wo[5:2] - 4'h2);
   assign blk_glb = paddr[15:8] == BLK_GLB;
   assign blk_seq = paddr[15:8] == BLK_SEQ;
   assign blk_fld = paddr[15:8] == BLK_FLD;
   assign blk_tog = paddr[15:12] == BLK_TOG && paddr[8:5] < 4'(NOUT)
      && paddr[4:2] < 3'(NTOG);
   assign pat.grp = paddr[11:9];
   assign pat.out_idx = paddr[8:5];
   assign pat.tog_idx = paddr[4:2];
   assign pat.wr_data = pwdata[PW-1:0];
   assign pat.wr_en = wr_done & blk_tog;

   always_comb begin
      rd_val = REG_RST;
      dec_err = 1'b0;
      if (blk_glb && wo == A_CTRL) begin
         rd_val[CTRL_RUN] = run_en;
      end else if (blk_glb && wo == A_STATUS) begin
         rd_val[0] = run;
         rd_val[ST_SLOT_LSB +: 2] = slot;
         rd_val[ST_REGION_LSB +: 4] = region;
         rd_val[ST_LINE_LSB +: RW] = rline;
         rd_val[ST_FIELD_LSB +: 2] = fld;
      end else if (blk_glb && wo == A_MODE) begin
         rd_val[2:0] = mode_cnt;
         for (int k = 0; k < NFIELD; k++) begin
            rd_val[MODE_ORD_LSB + 2*k +: 2] = mode_ord[k];
         end
      end else if (blk_seq) begin
         unique case (wo)
            SQ_CTRL: rd_val[15:0] = sq_ctrl[bi];
            SQ_START_A: rd_val[PW-1:0] = sq_start[bi][0];
            SQ_START_B: rd_val[PW-1:0] = sq_start[bi][1];
            SQ_LEN_A: rd_val[PW-1:0] = sq_len[bi][0];
            SQ_LEN_B: rd_val[PW-1:0] = sq_len[bi][1];
            SQ_REP_A, 6'h18, 6'h1C, 6'h20:
               rd_val[RW-1:0] = sq_rep_a[bi][2'(wo[5:2] - 4'h5)];
            SQ_REP_B_ODD: rd_val[RW-1:0] = sq_rep_b[bi][0];
            SQ_REP_B_EVEN: rd_val[RW-1:0] = sq_rep_b[bi][1];
            SQ_LINE_LEN: rd_val[PW-1:0] = sq_line_len[bi];
            SQ_POL: rd_val[NOUT-1:0] = sq_pol[bi];
            SQ_GROUP: rd_val[NGSEL-1:0] = sq_grp[bi];
            SQ_MASK1: rd_val = {3'h0, sq_me[bi][0], 3'h0, sq_mb[bi][0]};
            SQ_MASK2: rd_val = {3'h0, sq_me[bi][1], 3'h0, sq_mb[bi][1]};
            default: dec_err = 1'b1;
         endcase
      end else if (blk_fld && wo == FD_CFG) begin
         rd_val[3:0] = fd_nreg[bi];
      end else if (blk_fld && wo == FD_LAST) begin
         rd_val[PW-1:0] = fd_last[bi];
      end else if (blk_fld && wo >= FD_REGION && ri < 4'(NREG)) begin
         rd_val[RW-1:0] = fd_rlines[bi][ri];
         rd_val[REG_SEQ_LSB +: 2] = fd_rseq[bi][ri];
      end else if (blk_tog) begin
         rd_val[PW-1:0] = pat.rd_data;
      end else begin
         dec_err = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= REG_RST;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & dec_err;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? REG_RST : rd_val;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         run_en <= 1'b0;
         mode_cnt <= '0;
         for (int s = 0; s < NSEQ; s++) begin
            sq_ctrl[s] <= '0;
            sq_line_len[s] <= '0;
            sq_pol[s] <= '0;
            sq_grp[s] <= '0;
            for (int g = 0; g < 2; g++) begin
               sq_start[s][g] <= '0;
               sq_len[s][g] <= '0;
               sq_rep_b[s][g] <= '0;
               sq_mb[s][g] <= '0;
               sq_me[s][g] <= '0;
            end
            for (int k = 0; k < 4; k++) begin
               sq_rep_a[s][k] <= '0;
            end
         end
         for (int f = 0; f < NFIELD; f++) begin
            mode_ord[f] <= '0;
            fd_nreg[f] <= '0;
            fd_last[f] <= '0;
            for (int r = 0; r < NREG; r++) begin
               fd_rlines[f][r] <= '0;
               fd_rseq[f][r] <= '0;
            end
         end
      end else if (wr_done && !dec_err) begin
         if (blk_glb && wo == A_CTRL) begin
            run_en <= pwdata[CTRL_RUN];
         end
         if (blk_glb && wo == A_MODE) begin
            mode_cnt <= pwdata[2:0];
            for (int k = 0; k < NFIELD; k++) begin
               mode_ord[k] <= pwdata[MODE_ORD_LSB + 2*k +: 2];
            end
         end
         if (blk_seq) begin
            unique case (wo)
               SQ_CTRL: sq_ctrl[bi] <= pwdata[15:0];
               SQ_START_A: sq_start[bi][0] <= pwdata[PW-1:0];
               SQ_START_B: sq_start[bi][1] <= pwdata[PW-1:0];
               SQ_LEN_A: sq_len[bi][0] <= pwdata[PW-1:0];
               SQ_LEN_B: sq_len[bi][1] <= pwdata[PW-1:0];
               SQ_REP_A, 6'h18, 6'h1C, 6'h20:
                  sq_rep_a[bi][2'(wo[5:2] - 4'h5)] <= pwdata[RW-1:0];
               SQ_REP_B_ODD: sq_rep_b[bi][0] <= pwdata[RW-1:0];
               SQ_REP_B_EVEN: sq_rep_b[bi][1] <= pwdata[RW-1:0];
               SQ_LINE_LEN: sq_line_len[bi] <= pwdata[PW-1:0];
               SQ_POL: sq_pol[bi] <= pwdata[NOUT-1:0];
               SQ_GROUP: sq_grp[bi] <= pwdata[NGSEL-1:0];
               SQ_MASK1: begin
                  sq_mb[bi][0] <= pwdata[PW-1:0];
                  sq_me[bi][0] <= pwdata[MSK_END_LSB +: PW];
               end
               SQ_MASK2: begin
                  sq_mb[bi][1] <= pwdata[PW-1:0];
                  sq_me[bi][1] <= pwdata[MSK_END_LSB +: PW];
               end
            endcase
         end
         if (blk_fld && wo == FD_CFG) begin
            fd_nreg[bi] <= pwdata[3:0];
         end
         if (blk_fld && wo == FD_LAST) begin
            fd_last[bi] <= pwdata[PW-1:0];
         end
         if (blk_fld && wo >= FD_REGION && ri < 4'(NREG)) begin
            fd_rlines[bi][ri] <= pwdata[RW-1:0];
            fd_rseq[bi][ri] <= pwdata[REG_SEQ_LSB +: 2];
         end
      end
   end

   // ----------------------------------------------------------
   // line, region, field walk
   // ----------------------------------------------------------
   always_comb begin
      run = state == CVTG_RUN;
      fld = mode_ord[slot];
      cs = fd_rseq[fld][region];
      sc = sq_ctrl[cs];
      last_reg = (5'({1'b0, region}) + 5'h01 >= 5'({1'b0, fd_nreg[fld]}))
         || region == 4'h8;
      last_rl = rline == RW'(fd_rlines[fld][region] - 12'h001);
      last_slot = 3'({1'b0, slot}) + 3'h1 >= mode_cnt;
      line_len = (last_reg && last_rl) ? fd_last[fld]
         : sq_line_len[cs];
      // zero wraps to 8191, giving the full 8192 pixel line
      line_end = pix == PW'(line_len - 13'h0001);
      masked = run && ((sc[SQ_MASK_LSB] && pix >= sq_mb[cs][0]
         && pix < sq_me[cs][0]) || (sc[SQ_MASK_LSB+1]
         && pix >= sq_mb[cs][1] && pix < sq_me[cs][1]));
      frozen = masked && !sc[SQ_HOLD];
      a_idx = (sc[SQ_ALT_LSB +: 2] == 2'h0) ? 2'h0 : lalt;
      g_start[0] = sq_start[cs][0];
      g_start[1] = sq_start[cs][1];
      g_len[0] = sq_len[cs][0];
      g_len[1] = sq_len[cs][1];
      g_reps[0] = sq_rep_a[cs][a_idx];
      g_reps[1] = rline[0] ? sq_rep_b[cs][1] : sq_rep_b[cs][0];
   end

   assign pat.sel_a = sc[SQ_SELA_LSB +: GW];
   assign pat.sel_b = sc[SQ_SELB_LSB +: GW];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= CVTG_IDLE;
         slot <= '0;
         region <= '0;
         rline <= '0;
         lalt <= '0;
         pix <= '0;
      end else begin
         unique case (state)
            CVTG_IDLE: begin
               slot <= '0;
               region <= '0;
               rline <= '0;
               lalt <= '0;
               pix <= '0;
               if (run_en) begin
                  state <= CVTG_RUN;
               end
            end
            CVTG_RUN: begin
               if (!run_en) begin
                  state <= CVTG_IDLE;
               end else if (line_end) begin
                  pix <= '0;
                  lalt <= (lalt == sc[SQ_ALT_LSB +: 2]) ? 2'h0
                     : 2'(lalt + 2'h1);
                  if (last_rl) begin
                     rline <= '0;
                     lalt <= '0;
                     if (last_reg) begin
                        region <= '0;
                        slot <= last_slot ? 2'h0 : 2'(slot + 2'h1);
                     end else begin
                        region <= 4'(region + 4'h1);
                     end
                  end else begin
                     rline <= RW'(rline + 12'h001);
                  end
               end else begin
                  pix <= PW'(pix + 13'h0001);
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // pattern groups a and b
   // ----------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_grp
      always_ff @(posedge sys_clk) begin
         if (rst || !run || line_end) begin
            g_act[g] <= 1'b0;
            g_rel[g] <= '0;
            g_cnt[g] <= '0;
         end else if (!g_act[g]) begin
            if (pix == g_start[g] && g_reps[g] != '0 && !frozen) begin
               g_act[g] <= 1'b1;
               g_rel[g] <= '0;
               g_cnt[g] <= RW'(1);
            end
         end else if (!frozen) begin
            // freeze parks the pattern; it carries on at resume
            if (g_rel[g] == PW'(g_len[g] - 13'h0001)) begin
               g_rel[g] <= '0;
               if (g_cnt[g] == g_reps[g]) begin
                  g_act[g] <= 1'b0;
               end else begin
                  g_cnt[g] <= RW'(g_cnt[g] + 12'h001);
               end
            end else begin
               g_rel[g] <= PW'(g_rel[g] + 13'h0001);
            end
         end
      end
   end

   // ----------------------------------------------------------
   // output levels
   // ----------------------------------------------------------
   for (genvar o = 0; o < NOUT; o++) begin : g_lvl
      logic gb;
      logic par;
      logic [PW-1:0] tv;
      if (o < NGSEL) begin : g_sel
         assign gb = sq_grp[cs][o];
      end else begin : g_fix
         // the last phase has no assignment bit and follows group a
         assign gb = 1'b0;
      end
      always_comb begin
         par = 1'b0;
         tv = '0;
         for (int t = 0; t < NTOG; t++) begin
            tv = gb ? pat.tog_b[(o*NTOG+t)*PW +: PW]
               : pat.tog_a[(o*NTOG+t)*PW +: PW];
            if (tv != TOG_IGN_LO && tv != TOG_IGN_HI
               && tv <= g_rel[gb]) begin
               par = ~par;
            end
         end
         lvl[o] = sq_pol[cs][o] ^ (g_act[gb] & par);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || !run) begin
         vert_phase <= '0;
      end else if (!masked) begin
         vert_phase <= lvl;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         horiz_drive <= 1'b0;
      end else begin
         horiz_drive <= (state == CVTG_IDLE && run_en)
            || (run && run_en && line_end);
      end
   end
endmodule // cvtg_top

// *** include/cvtg_pkg.sv ***
// Purpose: shared constants for the vertical timing generator
// Assumes: apb register map, one aligned 32-bit word per register
// Notes: pattern toggle memory is not reset
package cvtg_pkg;
   // ----------------------------------------------------------
   // sizes
   // ----------------------------------------------------------
   localparam int NOUT = 13;
   localparam int NTOG = 6;
   localparam int PW = 13;
   localparam int RW = 12;
   localparam int NGSEL = 12;
   localparam int NREG = 9;
   localparam int NSEQ = 4;
   localparam int NFIELD = 4;
   localparam int NPAT = 8;
   localparam int GW = 3;
   localparam logic [PW-1:0] TOG_IGN_LO = 13'h0000;
   localparam logic [PW-1:0] TOG_IGN_HI = 13'h1FFF;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam logic [7:0] BLK_GLB = 8'h00;
   localparam logic [7:0] BLK_SEQ = 8'h01;
   localparam logic [7:0] BLK_FLD = 8'h02;
   localparam logic [3:0] BLK_TOG = 4'h1;
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_STATUS = 6'h04;
   localparam logic [5:0] A_MODE = 6'h08;
   localparam logic [5:0] SQ_CTRL = 6'h00;
   localparam logic [5:0] SQ_START_A = 6'h04;
   localparam logic [5:0] SQ_START_B = 6'h08;
   localparam logic [5:0] SQ_LEN_A = 6'h0C;
   localparam logic [5:0] SQ_LEN_B = 6'h10;
   localparam logic [5:0] SQ_REP_A = 6'h14;
   localparam logic [5:0] SQ_REP_B_ODD = 6'h24;
   localparam logic [5:0] SQ_REP_B_EVEN = 6'h28;
   localparam logic [5:0] SQ_LINE_LEN = 6'h2C;
   localparam logic [5:0] SQ_POL = 6'h30;
   localparam logic [5:0] SQ_GROUP = 6'h34;
   localparam logic [5:0] SQ_MASK1 = 6'h38;
   localparam logic [5:0] SQ_MASK2 = 6'h3C;
   localparam logic [5:0] FD_CFG = 6'h00;
   localparam logic [5:0] FD_LAST = 6'h04;
   localparam logic [5:0] FD_REGION = 6'h08;
   // ----------------------------------------------------------
   // field positions
   // ----------------------------------------------------------
   localparam int CTRL_RUN = 0;
   localparam int MODE_ORD_LSB = 8;
   localparam int SQ_SELA_LSB = 0;
   localparam int SQ_SELB_LSB = 5;
   localparam int SQ_MASK_LSB = 10;
   localparam int SQ_HOLD = 12;
   localparam int SQ_ALT_LSB = 13;
   localparam int MSK_END_LSB = 16;
   localparam int REG_SEQ_LSB = 16;
   localparam int ST_SLOT_LSB = 1;
   localparam int ST_REGION_LSB = 4;
   localparam int ST_LINE_LSB = 8;
   localparam int ST_FIELD_LSB = 20;
   typedef enum logic [0:0] {
      CVTG_IDLE = 1'b0,
      CVTG_RUN = 1'b1
   } cvtg_state_t;
endpackage

// *** include/cvtg_pat_if.sv ***
// Purpose: link between the engine and the pattern group memory
// Assumes: one clock, sys_clk
// Notes: tog_a and tog_b hold all toggles of the two selected groups
`timescale 1ns/1ns
interface cvtg_pat_if;
   import cvtg_pkg::*;
   logic wr_en;
   logic [GW-1:0] grp;
   logic [3:0] out_idx;
   logic [2:0] tog_idx;
   logic [PW-1:0] wr_data;
   logic [PW-1:0] rd_data;
   logic [GW-1:0] sel_a;
   logic [GW-1:0] sel_b;
   logic [NOUT*NTOG*PW-1:0] tog_a;
   logic [NOUT*NTOG*PW-1:0] tog_b;
   modport host (output wr_en, grp, out_idx, tog_idx, wr_data, sel_a,
      sel_b, input rd_data, tog_a, tog_b);
   modport mem (input wr_en, grp, out_idx, tog_idx, wr_data, sel_a,
      sel_b, output rd_data, tog_a, tog_b);
endinterface

// *** src/cvtg_pattern_mem.sv ***
// Purpose: pattern group toggle storage
// Assumes: caller only writes legal output and toggle indices
// Notes: contents are undefined after reset, software loads them
`timescale 1ns/1ns
module cvtg_pattern_mem
   import cvtg_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // engine side
   cvtg_pat_if.mem pat
);
   logic [PW-1:0] mem [NPAT][NOUT][NTOG];

   always_ff @(posedge sys_clk) begin
      if (pat.wr_en) begin
         mem[pat.grp][pat.out_idx][pat.tog_idx] <= pat.wr_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (pat.out_idx < 4'(NOUT) && pat.tog_idx < 3'(NTOG)) begin
         pat.rd_data <= mem[pat.grp][pat.out_idx][pat.tog_idx];
      end else begin
         pat.rd_data <= '0;
      end
   end

   // snapshot of both selected groups; lags the select by one cycle
   // one process, so each snapshot word has a single driver
   always_ff @(posedge sys_clk) begin
      for (int o = 0; o < NOUT; o++) begin
         for (int t = 0; t < NTOG; t++) begin
            pat.tog_a[(o*NTOG+t)*PW +: PW] <= mem[pat.sel_a][o][t];
            pat.tog_b[(o*NTOG+t)*PW +: PW] <= mem[pat.sel_b][o][t];
         end
      end
   end
endmodule // cvtg_pattern_mem

// *** test/cvtg_asserts.sv ***
// Purpose: port checks for the vertical timing generator
// Assumes: apb master holds each request until pready
// Notes: run state is rebuilt from apb writes to ctrl
`timescale 1ns/1ns
module cvtg_asserts
   import cvtg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sensor drive
   input wire logic [NOUT-1:0] vert_phase,
   input wire logic horiz_drive
);
   logic run_q;
   logic [1:0] idle_cnt;
   logic [13:0] gap;
   wire ctrl_wr = psel & penable & pready & pwrite & (paddr[15:2] == 14'h0);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge sys_clk) begin
      if (rst)
         run_q <= 1'b0;
      else if (ctrl_wr)
         run_q <= pwdata[0];
   end
   // engine needs a cycle to go idle, so allow margin
   always_ff @(posedge sys_clk) begin
      if (rst || run_q)
         idle_cnt <= 2'h0;
      else if (idle_cnt != 2'h3)
         idle_cnt <= idle_cnt + 2'h1;
   end
   always_ff @(posedge sys_clk) begin
      if (rst || !run_q || horiz_drive)
         gap <= 14'h0000;
      else if (gap != 14'h3FFF)
         gap <= gap + 14'h0001;
   end
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read data not zero");
   mapped_ok_a: assert property (pready && paddr[15:4] == 12'h000
      && paddr[3:2] != 2'h3 |-> !pslverr)
      else $error("global register refused");
   rst_out_a: assert property (disable iff (1'b0) rst |=>
      vert_phase == 13'h0000 && !horiz_drive && !pready)
      else $error("outputs not cleared by reset");
   idle_zero_a: assert property (idle_cnt == 2'h3 |->
      vert_phase == 13'h0000 && !horiz_drive)
      else $error("outputs active while stopped");
   line_bound_a: assert property (gap <= 14'h2000)
      else $error("line longer than 8192 pixels");
endmodule // cvtg_asserts
bind cvtg_top cvtg_asserts i_chk (.sys_clk(sys_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .vert_phase(vert_phase),
   .horiz_drive(horiz_drive));

// *** test/cvtg_sensor_model.sv ***
// Purpose: sensor side that measures the vertical drive it receives
// Assumes: first phase carries the pattern under test
// Notes: first values after start are not meaningful
`timescale 1ns/1ns
module cvtg_sensor_model
   import cvtg_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // drive from the generator
   input wire logic [NOUT-1:0] vert_phase,
   input wire logic horiz_drive,
   // measurements
   output logic [13:0] line_gap,
   output logic [3:0] line_shifts,
   output logic [7:0] hi_width,
   output logic [7:0] shift_gap
);
   logic [13:0] pix;
   logic [3:0] shifts;
   logic [7:0] hi_cnt;
   logic [7:0] since;
   logic prev;
   wire rise = vert_phase[0] & !prev;
   always_ff @(posedge sys_clk) begin
      prev <= vert_phase[0];
      pix <= horiz_drive ? 14'h0001 : pix + 14'h0001;
      shifts <= horiz_drive ? 4'h0 : shifts + {3'h0, rise};
      hi_cnt <= vert_phase[0] ? hi_cnt + 8'h01 : 8'h00;
      since <= rise ? 8'h01 : since + 8'h01;
      if (horiz_drive)
         line_gap <= pix;
      if (horiz_drive)
         line_shifts <= shifts;
      if (prev && !vert_phase[0])
         hi_width <= hi_cnt;
      if (rise)
         shift_gap <= since;
   end
endmodule // cvtg_sensor_model

// *** test/ccd_vertical_timing_generator_tb.sv ***
// Purpose: self-checking bench for the vertical timing generator
// Assumes: one field, one region, sequence zero, group zero
// Notes: unused toggles are parked since memory is not reset
`timescale 1ns/1ns
module ccd_vertical_timing_generator_tb import cvtg_pkg::*;;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic horiz_drive;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NOUT-1:0] vert_phase;
   logic [13:0] line_gap;
   logic [3:0] line_shifts;
   logic [7:0] hi_width, shift_gap;
   int errors = 0;
   int n_compared = 0;
   cvtg_top i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .vert_phase(vert_phase),
      .horiz_drive(horiz_drive));
   cvtg_sensor_model i_sensor (.sys_clk(sys_clk),
      .vert_phase(vert_phase), .horiz_drive(horiz_drive),
      .line_gap(line_gap), .line_shifts(line_shifts),
      .hi_width(hi_width), .shift_gap(shift_gap));
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] a,
      input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_hd();
      @(posedge sys_clk);
      while (horiz_drive !== 1'b1)
         @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic test_regs();
      apb(1'b0, 16'h0000, 32'h0);
      chk(rd, REG_RST);
      apb(1'b1, 16'h0104, 32'h0000_000A);
      apb(1'b0, 16'h0104, 32'h0);
      chk(rd, 32'h0000_000A);
      apb(1'b0, 16'h11A0, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test regs done");
   endtask
   task automatic test_pattern();
      for (int o = 0; o < NOUT; o++)
         for (int t = 0; t < NTOG; t++)
            apb(1'b1, 16'h1000 + 16'(o * 32 + t * 4),
               (t % 2) ? 32'h1FFF : 32'h0);
      apb(1'b1, 16'h1000, 32'h5);
      apb(1'b1, 16'h1004, 32'h9);
      apb(1'b1, 16'h0100, 32'h0);
      apb(1'b1, 16'h010C, 32'h14);
      apb(1'b1, 16'h0114, 32'h2);
      apb(1'b1, 16'h0124, 32'h0);
      apb(1'b1, 16'h0128, 32'h0);
      apb(1'b1, 16'h012C, 32'h64);
      apb(1'b1, 16'h0130, 32'h2);
      apb(1'b1, 16'h0134, 32'h0);
      apb(1'b1, 16'h0200, 32'h1);
      apb(1'b1, 16'h0204, 32'h3C);
      apb(1'b1, 16'h0208, 32'h2);
      apb(1'b1, 16'h0008, 32'h0);
      apb(1'b1, 16'h0000, 32'h1);
      wait_hd();
      wait_hd();
      chk(32'(line_gap), 32'h64);
      chk(32'(line_shifts), 32'h2);
      chk(32'(hi_width), 32'h4);
      chk(32'(shift_gap), 32'h14);
      chk({31'h0, vert_phase[1]}, 32'h1);
      chk({31'h0, vert_phase[2]}, 32'h0);
      wait_hd();
      chk(32'(line_gap), 32'h3C);
      $display("test pattern done");
   endtask
   task automatic test_mask();
      apb(1'b1, 16'h0138, 32'h0027_0025);
      apb(1'b1, 16'h0100, 32'h0000_0400);
      wait_hd();
      wait_hd();
      chk(32'(hi_width), 32'h6);
      apb(1'b1, 16'h0100, 32'h0000_1400);
      wait_hd();
      wait_hd();
      chk(32'(hi_width), 32'h4);
      $display("test mask done");
   endtask
   task automatic test_stop();
      apb(1'b1, 16'h0000, 32'h0);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(32'(vert_phase), 32'h0);
      chk({31'h0, horiz_drive}, 32'h0);
      $display("test stop done");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #(100 * 20000);
      errors++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      test_regs();
      test_pattern();
      test_mask();
      test_stop();
      complete_run();
   end
endmodule // ccd_vertical_timing_generator_tb
